// File: tip_rsp.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Receive buffer
// ****************************************************************
module tip_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 16
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   // Depth must be a power of two for the pointer wrap to work
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;

   assign in_ready  = (wr_q != {~rd_q[AW], rd_q[AW-1:0]});
   assign out_valid = (wr_q != rd_q);
   assign out_data  = mem[rd_q[AW-1:0]];

   always_ff @(posedge clock) begin
      if (in_valid && in_ready) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wr_q <= '0;
      end else if (in_valid && in_ready) begin
         wr_q <= wr_q + {{AW{1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         rd_q <= '0;
      end else if (out_valid && out_ready) begin
         rd_q <= rd_q + {{AW{1'b0}}, 1'b1};
      end
   end
endmodule : tip_fifo

// ****************************************************************
// Invalidation target
// ****************************************************************
module tip_rsp #(
   parameter logic [7:0] OWN_BUS = 8'h00,
   parameter logic [4:0] OWN_DEV = 5'h02,
   parameter logic [2:0] OWN_FN  = 3'h0,
   parameter logic [4:0] UNIT_ID = 5'h02,
   parameter int         DEPTH   = 16
) (
   input  wire logic        clock,
   input  wire logic        rst,
   tip_link_if.rsp_end      link,
   output logic             inv_valid,
   input  wire logic        inv_ready,
   output logic [4:0]       inv_tag,
   output logic [7:0]       inv_src_bus,
   output logic [4:0]       inv_src_dev,
   output logic [2:0]       inv_src_fn,
   output logic [63:12]     inv_vaddr,
   output logic             inv_size,
   input  wire logic        cpl_valid,
   output logic             cpl_ready,
   input  wire logic [31:0] cpl_vec,
   input  wire logic [7:0]  cpl_bus,
   input  wire logic [4:0]  cpl_dev,
   input  wire logic [2:0]  cpl_fn,
   input  wire logic        bridged,
   input  wire logic [3:0]  tc_count,
   output logic             busy
);

   // ****************************************************************
   // Request intake through the buffer
   // ****************************************************************
   logic       fo_valid;
   logic       fo_ready;
   logic [9:0] fo_data;
   logic       inv_valid_q;
   logic       rx_end_q;

   tip_fifo #(.WIDTH(10), .DEPTH(DEPTH)) u_fifo (
      .clock     (clock),
      .rst       (rst),
      .in_valid  (link.req_valid),
      .in_ready  (link.req_ready),
      .in_data   ({link.req_last, link.req_ctl, link.req_data}),
      .out_valid (fo_valid),
      .out_ready (fo_ready),
      .out_data  (fo_data)
   );

   // Parsing stalls while a decoded request waits for the user and for one cycle after a full request's last byte
   assign fo_ready = !inv_valid_q && !rx_end_q;

   logic [7:0] rx_q [0:19];
   logic [4:0] rx_idx_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         rx_idx_q <= 5'h00;
         rx_end_q <= 1'b0;
      end else begin
         rx_end_q <= fo_valid && fo_ready && fo_data[9]
                     && (rx_idx_q == 5'(tip_pkg::REQ_LEN - 1));   // [RULE10]
         if (fo_valid && fo_ready) begin
            if (fo_data[9]) begin
               rx_idx_q <= 5'h00;
            end else if (rx_idx_q != 5'h1F) begin
               rx_idx_q <= rx_idx_q + 5'h01;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (fo_valid && fo_ready && rx_idx_q < 5'(tip_pkg::REQ_LEN)) begin
         rx_q[rx_idx_q] <= fo_data[7:0];
      end
   end

   logic hit;

   assign hit = rx_end_q && !rx_q[7][tip_pkg::FLAG_BIT]          // [RULE3]
                && tip_pkg::is_posted(rx_q[4])                    // [RULE2]
                && rx_q[0] == tip_pkg::BYTE0_EXT
                && rx_q[10] == tip_pkg::WIN_LO && rx_q[11] == tip_pkg::WIN_HI
                && rx_q[8] == {OWN_DEV, OWN_FN} && rx_q[9] == OWN_BUS; // [RULE10]

   // ****************************************************************
   // Decoded request to the user
   // ****************************************************************
   logic [4:0]   tag_q;
   logic [7:0]   sbus_q;
   logic [4:0]   sdev_q;
   logic [2:0]   sfn_q;
   logic [63:12] va_q;
   logic         size_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         inv_valid_q <= 1'b0;
      end else if (hit) begin
         inv_valid_q <= 1'b1;                                     // [RULE1]
      end else if (inv_ready) begin
         inv_valid_q <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         tag_q  <= 5'h00;
         sbus_q <= 8'h00;
         sdev_q <= 5'h00;
         sfn_q  <= 3'h0;
         va_q   <= '0;
         size_q <= 1'b0;
      end else if (hit) begin
         tag_q  <= rx_q[12][7:3];
         sbus_q <= rx_q[2];
         sdev_q <= rx_q[1][7:3];
         sfn_q  <= rx_q[1][2:0];
         va_q   <= {rx_q[19], rx_q[18], rx_q[17], rx_q[16], rx_q[15], rx_q[14],
                    rx_q[13][7:4]};
         size_q <= rx_q[13][3];
      end
   end

   assign inv_valid   = inv_valid_q;
   assign inv_tag     = tag_q;
   assign inv_src_bus = sbus_q;
   assign inv_src_dev = sdev_q;
   assign inv_src_fn  = sfn_q;
   assign inv_vaddr   = va_q;
   assign inv_size    = size_q;

   // ****************************************************************
   // Completion gathering
   // ****************************************************************
   // One target is held; a completion for another requester is taken at once,
   // replaces the held target and merges its tags into the pending set
   tip_pkg::tip_tx_state_t state_q;
   logic [31:0] pend_q;
   logic [7:0]  tbus_q;
   logic [4:0]  tdev_q;
   logic [2:0]  tfn_q;
   logic        take;

   assign cpl_ready = 1'b1;
   assign take      = (state_q == tip_pkg::TX_IDLE) && (pend_q != 32'h0);

   always_ff @(posedge clock) begin
      if (rst) begin
         pend_q <= 32'h0;
      end else if (cpl_valid) begin
         pend_q <= (take ? 32'h0 : pend_q) | cpl_vec;              // [RULE4]
      end else if (take) begin
         pend_q <= 32'h0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         tbus_q <= 8'h00;
         tdev_q <= 5'h00;
         tfn_q  <= 3'h0;
      end else if (cpl_valid) begin
         tbus_q <= cpl_bus;
         tdev_q <= cpl_dev;
         tfn_q  <= cpl_fn;
      end
   end

   // ****************************************************************
   // Response sender
   // ****************************************************************
   logic [31:0]  cur_vec_q;
   logic [15:0]  cur_tgt_q;
   logic [3:0]   num_q;
   logic [3:0]   k_q;
   logic         brg_q;
   logic [127:0] tx_sr_q;
   logic [15:0]  tx_ctl_q;
   logic [4:0]   tx_left_q;
   logic         isoc_q;
   logic [2:0]   cc;

   assign cc = tip_pkg::num_to_cc(num_q);                          // [RULE8]

   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= tip_pkg::TX_IDLE;
      end else begin
         case (state_q)
            tip_pkg::TX_IDLE: begin
               if (take) begin
                  state_q <= tip_pkg::TX_LOAD;
               end
            end
            tip_pkg::TX_LOAD: begin
               state_q <= tip_pkg::TX_SEND;
            end
            tip_pkg::TX_SEND: begin
               if (link.rsp_ready && tx_left_q == 5'h01) begin
                  state_q <= (k_q + 4'h1 >= num_q) ? tip_pkg::TX_IDLE
                                                   : tip_pkg::TX_LOAD;
               end
            end
            default: begin
               state_q <= tip_pkg::TX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cur_vec_q <= 32'h0;
         cur_tgt_q <= 16'h0;
         num_q     <= 4'h1;
         brg_q     <= 1'b0;
         k_q       <= 4'h0;
      end else if (take) begin
         cur_vec_q <= pend_q;
         cur_tgt_q <= {tbus_q, tdev_q, tfn_q};
         brg_q     <= bridged;
         k_q       <= 4'h0;
         if (!bridged) begin
            num_q <= tip_pkg::NORM_ISOC;                           // [RULE6]
         end else if (tc_count == 4'h0 || tc_count > 4'h8) begin
            num_q <= 4'h1;
         end else begin
            num_q <= tc_count;                                     // [RULE7]
         end
      end else if (state_q == tip_pkg::TX_SEND && link.rsp_ready
                   && tx_left_q == 5'h01) begin
         k_q <= k_q + 4'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         tx_sr_q   <= '0;
         tx_ctl_q  <= '0;
         tx_left_q <= 5'h00;
         isoc_q    <= 1'b0;
      end else if (state_q == tip_pkg::TX_LOAD) begin
         tx_sr_q   <= {cur_vec_q,                                  // [RULE5]
                       tip_pkg::WIN_HI, tip_pkg::WIN_LO,
                       cur_tgt_q[15:8], cur_tgt_q[7:0],
                       2'h0, cc, 1'b1, 2'h0,                       // [RULE3]
                       tip_pkg::RSP_BYTE6, 3'h0, UNIT_ID,          // [RULE10]
                       tip_pkg::BYTE4_PW, 8'h00,                   // [RULE2]
                       OWN_BUS, OWN_DEV, OWN_FN, tip_pkg::BYTE0_EXT};
         tx_ctl_q  <= tip_pkg::RSP_CTL;
         tx_left_q <= 5'(tip_pkg::RSP_LEN);
         isoc_q    <= !brg_q && (k_q == 4'h1);                     // [RULE6]
      end else if (state_q == tip_pkg::TX_SEND && link.rsp_ready) begin
         tx_sr_q   <= {8'h00, tx_sr_q[127:8]};
         tx_ctl_q  <= {1'b0, tx_ctl_q[15:1]};
         tx_left_q <= tx_left_q - 5'h01;
      end
   end

   assign link.rsp_valid = (state_q == tip_pkg::TX_SEND);
   assign link.rsp_data  = tx_sr_q[7:0];
   assign link.rsp_ctl   = tx_ctl_q[0];
   assign link.rsp_isoc  = isoc_q;
   assign link.rsp_last  = (tx_left_q == 5'h01);
   assign busy           = (state_q != tip_pkg::TX_IDLE);

endmodule : tip_rsp
`default_nettype wire

// File: tip_pkg.sv
// Notes on behaviour
// RULE1 - Translation holder issues invalidations; target accepts them
// RULE2 - Request and response travel as posted writes
// RULE3 - Response flag clear in requests, set in responses
// RULE4 - Responder may merge several tags into one response
// RULE5 - Tag vector bit n completes tag n
// RULE6 - Separate responses on normal and isochronous channels
// RULE7 - Bridged invalidations: one response per traffic class
// RULE8 - Completion count 000b means eight, else n
// RULE9 - Requester completes tag after all counted responses
// RULE10 - Fixed window, target ids, one or two doublewords
package tip_pkg;

   // ****************************************************************
   // Packet layout
   // ****************************************************************
   localparam int        REQ_LEN   = 20;
   localparam int        RSP_LEN   = 16;
   localparam int        TAGS      = 32;
   localparam logic [7:0] BYTE0_EXT = 8'hBE;
   localparam logic [7:0] BYTE4_PW  = 8'h2C;
   localparam logic [5:0] PW_MASK   = 6'h3D;
   localparam logic [5:0] PW_CMD    = 6'h2C;
   localparam logic [7:0] REQ_BYTE6 = 8'h40;
   localparam logic [7:0] RSP_BYTE6 = 8'h00;
   localparam logic [7:0] WIN_LO    = 8'hFB;
   localparam logic [7:0] WIN_HI    = 8'hFD;
   localparam int        FLAG_BIT  = 2;
   localparam int        CC_LSB    = 3;
   localparam logic [19:0] REQ_CTL  = 20'h00FFF;
   localparam logic [15:0] RSP_CTL  = 16'h0FFF;
   localparam logic [3:0] NORM_ISOC = 4'h2;

   // ****************************************************************
   // Response sender states
   // ****************************************************************
   typedef enum logic [1:0] {
      TX_IDLE = 2'h0,
      TX_LOAD = 2'h1,
      TX_SEND = 2'h3
   } tip_tx_state_t;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic is_posted(input logic [7:0] b);
      return (b[5:0] & PW_MASK) == PW_CMD;
   endfunction : is_posted

   function automatic logic [3:0] cc_to_num(input logic [2:0] cc);
      return (cc == 3'h0) ? 4'h8 : {1'b0, cc};
   endfunction : cc_to_num

   function automatic logic [2:0] num_to_cc(input logic [3:0] num);
      return num[2:0];
   endfunction : num_to_cc

endpackage : tip_pkg

// File: tip_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface tip_link_if;
   logic       req_valid;
   logic       req_ready;
   logic [7:0] req_data;
   logic       req_ctl;
   logic       req_isoc;
   logic       req_last;
   logic       rsp_valid;
   logic       rsp_ready;
   logic [7:0] rsp_data;
   logic       rsp_ctl;
   logic       rsp_isoc;
   logic       rsp_last;

   modport req_end (
      output req_valid, req_data, req_ctl, req_isoc, req_last, rsp_ready,
      input  req_ready, rsp_valid, rsp_data, rsp_ctl, rsp_isoc, rsp_last
   );
   modport rsp_end (
      input  req_valid, req_data, req_ctl, req_isoc, req_last, rsp_ready,
      output req_ready, rsp_valid, rsp_data, rsp_ctl, rsp_isoc, rsp_last
   );
endinterface : tip_link_if
`default_nettype wire

// File: tip_req.sv
`timescale 1ns/10ps
`default_nettype none
module tip_req #(
   parameter logic [7:0] SRC_BUS = 8'h00,
   parameter logic [4:0] SRC_DEV = 5'h01,
   parameter logic [2:0] SRC_FN  = 3'h0,
   parameter logic [4:0] UNIT_ID = 5'h01
) (
   input  wire logic        clock,
   input  wire logic        rst,
   tip_link_if.req_end      link,
   input  wire logic        inv_valid,
   output logic             inv_ready,
   input  wire logic [4:0]  inv_tag,
   input  wire logic [7:0]  inv_bus,
   input  wire logic [4:0]  inv_dev,
   input  wire logic [2:0]  inv_fn,
   input  wire logic [63:12] inv_vaddr,
   input  wire logic        inv_size,
   output logic             done_valid,
   output logic [31:0]      done_vec
);

   // ****************************************************************
   // Request sender
   // ****************************************************************
   logic [159:0] tx_sr_q;
   logic [19:0]  tx_ctl_q;
   logic [4:0]   tx_left_q;

   assign inv_ready      = (tx_left_q == 5'h00);
   assign link.req_valid = (tx_left_q != 5'h00);
   assign link.req_data  = tx_sr_q[7:0];
   assign link.req_ctl   = tx_ctl_q[0];
   assign link.req_isoc  = 1'b0;
   assign link.req_last  = (tx_left_q == 5'h01);

   always_ff @(posedge clock) begin
      if (rst) begin
         tx_sr_q   <= '0;
         tx_ctl_q  <= '0;
         tx_left_q <= 5'h00;
      end else if (inv_valid && inv_ready) begin
         tx_sr_q   <= {inv_vaddr[63:16], inv_vaddr[15:12], inv_size, 3'h0,
                       inv_tag, 3'h0, tip_pkg::WIN_HI, tip_pkg::WIN_LO,
                       inv_bus, inv_dev, inv_fn,
                       8'h00,                                     // [RULE3]
                       tip_pkg::REQ_BYTE6, 3'h0, UNIT_ID,         // [RULE10]
                       tip_pkg::BYTE4_PW, 8'h00,                  // [RULE2]
                       SRC_BUS, SRC_DEV, SRC_FN, tip_pkg::BYTE0_EXT}; // [RULE1]
         tx_ctl_q  <= tip_pkg::REQ_CTL;
         tx_left_q <= 5'(tip_pkg::REQ_LEN);
      end else if (link.req_valid && link.req_ready) begin
         tx_sr_q   <= {8'h00, tx_sr_q[159:8]};
         tx_ctl_q  <= {1'b0, tx_ctl_q[19:1]};
         tx_left_q <= tx_left_q - 5'h01;
      end
   end

   // ****************************************************************
   // Response receiver
   // ****************************************************************
   // Posted traffic is always sunk so it never blocks the channel
   assign link.rsp_ready = 1'b1;

   logic [7:0] rx_q [0:15];
   logic [3:0] rx_idx_q;
   logic       rx_end_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         rx_idx_q <= 4'h0;
         rx_end_q <= 1'b0;
      end else begin
         rx_end_q <= link.rsp_valid && link.rsp_last && (rx_idx_q == 4'hF);
         if (link.rsp_valid) begin
            rx_idx_q <= link.rsp_last ? 4'h0 : rx_idx_q + 4'h1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (link.rsp_valid) begin
         rx_q[rx_idx_q] <= link.rsp_data;
      end
   end

   logic        hit;
   logic [31:0] vec;
   logic [3:0]  need;
   logic [31:0] fin;

   assign hit  = rx_end_q && rx_q[7][tip_pkg::FLAG_BIT]          // [RULE3]
                 && tip_pkg::is_posted(rx_q[4])                   // [RULE2]
                 && rx_q[0] == tip_pkg::BYTE0_EXT
                 && rx_q[10] == tip_pkg::WIN_LO && rx_q[11] == tip_pkg::WIN_HI
                 && rx_q[8] == {SRC_DEV, SRC_FN} && rx_q[9] == SRC_BUS; // [RULE10]
   assign vec  = {rx_q[15], rx_q[14], rx_q[13], rx_q[12]};       // [RULE5]
   assign need = tip_pkg::cc_to_num(rx_q[7][tip_pkg::CC_LSB +: 3]); // [RULE8]

   // ****************************************************************
   // Per-tag response counting
   // ****************************************************************
   // Count comes from each response; mismatched counts are not checked
   for (genvar g = 0; g < tip_pkg::TAGS; g++) begin : g_tag
      logic [3:0] got_q;
      assign fin[g] = hit && vec[g] && (got_q + 4'h1 >= need);  // [RULE9]
      always_ff @(posedge clock) begin
         if (rst) begin
            got_q <= 4'h0;
         end else if (hit && vec[g]) begin
            got_q <= fin[g] ? 4'h0 : got_q + 4'h1;               // [RULE9]
         end
      end
   end

   logic        done_valid_q;
   logic [31:0] done_vec_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         done_valid_q <= 1'b0;
         done_vec_q   <= '0;
      end else begin
         done_valid_q <= |fin;
         done_vec_q   <= fin;
      end
   end

   assign done_valid = done_valid_q;
   assign done_vec   = done_vec_q;

endmodule : tip_req
`default_nettype wire

// File: tip_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module tip_monitor (
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       req_valid,
   input wire logic       req_ready,
   input wire logic [7:0] req_data,
   input wire logic       req_ctl,
   input wire logic       req_isoc,
   input wire logic       req_last,
   input wire logic       rsp_valid,
   input wire logic       rsp_ready,
   input wire logic [7:0] rsp_data,
   input wire logic       rsp_ctl,
   input wire logic       rsp_isoc,
   input wire logic       rsp_last
);
   // ********
   // Byte position in each packet
   // ********
   logic       req_take;
   logic       rsp_take;
   logic [4:0] req_cnt_q;
   logic [4:0] rsp_cnt_q;
   assign req_take = req_valid && req_ready;
   assign rsp_take = rsp_valid && rsp_ready;
   always_ff @(posedge clock) begin
      if (rst) req_cnt_q <= 5'h00;
      else if (req_take) req_cnt_q <= req_last ? 5'h00 : req_cnt_q + 5'h01;
   end
   always_ff @(posedge clock) begin
      if (rst) rsp_cnt_q <= 5'h00;
      else if (rsp_take) rsp_cnt_q <= rsp_last ? 5'h00 : rsp_cnt_q + 5'h01;
   end
   // ********
   // Checks
   // ********
   default clocking mon_cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_req_stall;
      req_valid && !req_ready;
   endsequence
   sequence s_rsp_end;
      rsp_take && rsp_last;
   endsequence
   AST_REQ_HEAD: assert property (
      req_take && req_cnt_q == 5'h00 |-> req_data == 8'hBE && !req_isoc)
      else $error("request head byte wrong");
   AST_REQ_CMD: assert property (
      req_take && req_cnt_q == 5'h04 |-> req_data == 8'h2C)
      else $error("request command byte wrong");
   AST_REQ_FLAG: assert property (
      req_take && req_cnt_q == 5'h07 |-> req_data[2] == 1'b0)
      else $error("request carries response flag");
   AST_REQ_FRAME: assert property (
      req_take |-> req_last == (req_cnt_q == 5'h13) && req_ctl == (req_cnt_q < 5'h0C))
      else $error("request framing wrong");
   AST_REQ_HOLD: assert property (
      s_req_stall |=> req_valid && $stable(req_data) && $stable(req_last))
      else $error("request byte dropped while stalled");
   AST_RSP_FLAG: assert property (
      rsp_take && rsp_cnt_q == 5'h07 |-> rsp_data[2] == 1'b1)
      else $error("response flag clear");
   AST_RSP_FRAME: assert property (
      rsp_take |-> rsp_last == (rsp_cnt_q == 5'h0F) && rsp_ctl == (rsp_cnt_q < 5'h0C))
      else $error("response framing wrong");
   AST_RSP_GAP: assert property (
      s_rsp_end |=> !rsp_valid)
      else $error("response copies not separated");
   AST_RSP_ISOC: assert property (
      rsp_take && rsp_cnt_q != 5'h00 |-> $stable(rsp_isoc))
      else $error("channel changed inside response");
endmodule : tip_monitor
`default_nettype wire

// File: translation_invalidation_packets_tb.sv
`timescale 1ns/10ps
`default_nettype none
module translation_invalidation_packets_tb;
   // ********
   // Bench
   // ********
   logic         clock, rst, q_valid, q_ready, q_size, done_valid;
   logic         t_valid, t_ready, t_size, cpl_valid, cpl_ready, bridged, busy;
   logic [4:0]   q_tag, q_dev, t_tag, t_dev, c_dev;
   logic [7:0]   t_bus, q_bus, c_bus;
   logic [2:0]   t_fn, q_fn, c_fn;
   logic [3:0]   tc_count;
   logic [63:12] q_va, t_va;
   logic [31:0]  done_vec, cpl_vec, seed;
   logic [79:0]  inv_q[$];
   logic [31:0]  done_q[$];
   int           errors, compares;
   tip_link_if link();
   // Requester keeps its default ids: bus 00, device 01, function 0
   tip_req tip_req_inst (
      .clock(clock), .rst(rst), .link(link), .inv_valid(q_valid), .inv_ready(q_ready),
      .inv_tag(q_tag), .inv_bus(q_bus), .inv_dev(q_dev), .inv_fn(q_fn), .inv_vaddr(q_va),
      .inv_size(q_size), .done_valid(done_valid), .done_vec(done_vec));
   tip_rsp #(.OWN_BUS(8'h34), .OWN_DEV(5'h05), .OWN_FN(3'h2)) tip_rsp_inst (
      .clock(clock), .rst(rst), .link(link), .inv_valid(t_valid), .inv_ready(t_ready),
      .inv_tag(t_tag), .inv_src_bus(t_bus), .inv_src_dev(t_dev), .inv_src_fn(t_fn),
      .inv_vaddr(t_va), .inv_size(t_size), .cpl_valid(cpl_valid), .cpl_ready(cpl_ready),
      .cpl_vec(cpl_vec), .cpl_bus(c_bus), .cpl_dev(c_dev), .cpl_fn(c_fn),
      .bridged(bridged), .tc_count(tc_count), .busy(busy));
   tip_monitor tip_monitor_inst (
      .clock(clock), .rst(rst), .req_valid(link.req_valid), .req_ready(link.req_ready),
      .req_data(link.req_data), .req_ctl(link.req_ctl), .req_isoc(link.req_isoc),
      .req_last(link.req_last), .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready),
      .rsp_data(link.rsp_data), .rsp_ctl(link.rsp_ctl), .rsp_isoc(link.rsp_isoc),
      .rsp_last(link.rsp_last));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic complete_run;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input string nm, input logic [79:0] s, input logic [79:0] e);
      compares++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   // Only requests aimed at the target are expected to surface there
   task automatic send(input logic [4:0] tag, input logic [4:0] dev);
      logic [63:0] r;
      int          n;
      // Let an edge pass so a following request never re-raises valid at once
      @(negedge clock);
      r = {rnd(), rnd()};
      {q_tag, q_dev, q_va, q_size} = {tag, dev, r[51:0], r[63]};
      if (dev == 5'h05 && q_bus == 8'h34 && q_fn == 3'h2) begin
         inv_q.push_back({tag, 8'h00, 5'h01, 3'h0, r[51:0], r[63]});
      end
      q_valid = 1'b1;
      n = 0;
      while (q_ready !== 1'b1 && n < 600) begin
         @(negedge clock);
         n++;
      end
      if (n >= 600) begin
         errors++;
         complete_run();
      end
      @(negedge clock);
      q_valid = 1'b0;
   endtask : send

   task automatic cpl(input logic [31:0] vec, input logic b, input logic [3:0] tc);
      {bridged, tc_count, cpl_vec, cpl_valid} = {b, tc, vec, 1'b1};
      done_q.push_back(vec);
      @(negedge clock);
      cpl_valid = 1'b0;
   endtask : cpl

   task automatic settle;
      int n;
      n = 0;
      while ((inv_q.size() > 0 || done_q.size() > 0 || busy !== 1'b0) && n < 3000) begin
         @(negedge clock);
         n++;
      end
      if (n >= 3000) begin
         errors++;
         complete_run();
      end
      repeat (4) @(negedge clock);
   endtask : settle

   task automatic run(input logic [4:0] tag, input logic b, input logic [3:0] tc);
      send(tag, 5'h05);
      cpl(32'h1 << tag, b, tc);
      settle();
   endtask : run

   always @(posedge clock) begin
      if (t_valid === 1'b1 && t_ready === 1'b1) begin
         chk("inv", {t_tag, t_bus, t_dev, t_fn, t_va, t_size},
             inv_q.size() > 0 ? inv_q.pop_front() : 'x);
      end
      if (done_valid === 1'b1) begin
         chk("done", done_vec, done_q.size() > 0 ? done_q.pop_front() : 'x);
      end
   end

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   initial begin
      logic [31:0] r;
      {q_valid, q_tag, q_dev, q_va, q_size} = '0;
      {cpl_valid, cpl_vec, bridged, tc_count} = '0;
      {q_bus, q_fn, c_bus, c_dev, c_fn} = {8'h34, 3'h2, 8'h00, 5'h01, 3'h0};
      rst = 1'b1;
      t_ready = 1'b1;
      seed = 32'h00000039;
      {errors, compares} = '0;
      repeat (6) @(negedge clock);
      rst = 1'b0;
      for (int i = 0; i < 4; i++) begin
         r = rnd();
         run(r[4:0], 1'b0, 4'h0);
      end
      $display("test single done");
      r = rnd();
      send(r[4:0], 5'h06);
      run(r[9:5], 1'b0, 4'h0);
      $display("test foreign target done");
      r = rnd();
      send(r[4:0], 5'h05);
      send(r[4:0] + 5'h01, 5'h05);
      cpl((32'h1 << r[4:0]) | (32'h1 << (r[4:0] + 5'h01)), 1'b0, 4'h0);
      settle();
      $display("test merge done");
      // Count 0 is out of range and must fall back to a single response
      for (int tc = 0; tc <= 8; tc++) begin
         run(5'(tc * 3), 1'b1, 4'(tc));
      end
      $display("test bridged done");
      t_ready = 1'b0;
      fork
         begin
            repeat (150) @(negedge clock);
            t_ready = 1'b1;
         end
      join_none
      for (int i = 0; i < 3; i++) begin
         r = rnd();
         send(r[4:0], 5'h05);
      end
      settle();
      $display("test backpressure done");
      complete_run();
   end
endmodule : translation_invalidation_packets_tb
`default_nettype wire
